// ---- eac_pkg.sv ----
// Constants and types shared by the non-volatile data memory access block
// What this block and its software do
// (RULE1) Nine-bit address split high/low; upper high bits read as zero.
// (RULE2) Bytes mapped linearly from address zero, one byte per address.
// (RULE3) Data register feeds programming; after a read it holds fetched byte.
// (RULE4) Control bits 7 and 6 are reserved and read as zero.
// (RULE5) Op select: 00 erase+write 3.4 ms, 01 erase, 10 write 1.8 ms.
// (RULE6) Op select writes are ignored while programming is busy.
// (RULE7) Reset clears op select to 00 unless programming is in progress.
// (RULE8) Ready interrupt held while enable, global enable and memory ready.
// (RULE9) Master program enable self-clears four cycles after being written.
// (RULE10) Trigger starts an operation only while master enable is still set.
// (RULE11) Trigger bit reads busy for the whole programming time.
// (RULE12) An accepted trigger stalls the processor for two cycles.
// (RULE13) Read strobe fetches byte at once and stalls processor four cycles; the code stalls two when an accepted trigger shares the write.
// (RULE14) While busy, read strobes are refused and address is frozen.
// (RULE15) Software checks busy is clear before issuing a read strobe; the bench also strobes while busy to test refusal and fetches without a check.
// (RULE16) Software loads a valid address before any memory access.
// (RULE17) Reset during programming lets the operation run to completion.
// (RULE18) Programming time is counted from the calibrated oscillator clock; the core counts processor clock cycles instead.
// (RULE19) Software erases a byte before a write-only operation.
// (RULE20) Reserved op code 11 starts nothing and leaves memory unchanged.
package eac_pkg;

	// Register select codes on the I/O port
	localparam logic [1:0] REG_ADDR_HIGH = 2'h0;
	localparam logic [1:0] REG_ADDR_LOW = 2'h1;
	localparam logic [1:0] REG_DATA = 2'h2;
	localparam logic [1:0] REG_CONTROL = 2'h3;

	// Control register field positions
	localparam int CTL_READ_STROBE = 0;
	localparam int CTL_PROGRAM_TRIGGER = 1;
	localparam int CTL_MASTER_ENABLE = 2;
	localparam int CTL_READY_IRQ_EN = 3;
	localparam int CTL_OP_LO = 4;
	localparam int CTL_OP_HI = 5;

	// Reset values and the erased byte value
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [8:0] ADDR_RESET = 9'h000;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Memory geometry
	localparam int ADDR_W = 9;
	localparam int MEM_BYTES = 512;

	// Timing: printed times, and cycle counts derived from the clock
	localparam int CLK_PERIOD_PS = 25000;
	localparam int ATOMIC_TIME_NS = 3400000;
	localparam int SPLIT_TIME_NS = 1800000;
	localparam int ATOMIC_CYCLES = ATOMIC_TIME_NS / (CLK_PERIOD_PS / 1000);
	localparam int SPLIT_CYCLES = SPLIT_TIME_NS / (CLK_PERIOD_PS / 1000);
	localparam int CNT_W = 18;
	localparam logic [2:0] MASTER_WINDOW = 3'h4;
	localparam logic [2:0] READ_STALL = 3'h4;
	localparam logic [2:0] PROGRAM_STALL = 3'h2;

	// Operation select codes
	typedef enum logic [1:0] {
		OP_ATOMIC = 2'h0,
		OP_ERASE = 2'h1,
		OP_WRITE = 2'h2,
		OP_RESERVED = 2'h3
	} eac_op_t;

endpackage

// ---- eac_core_if.sv ----
// Link between the register front end and the memory core
`timescale 1ns/1ps
interface eac_core_if;
	import eac_pkg::*;
	logic start;
	eac_op_t startOp;
	logic [ADDR_W-1:0] startAddr;
	logic [7:0] startData;
	logic busy;
	logic [ADDR_W-1:0] rdAddr;
	logic [7:0] rdData;

	modport ctrl (output start, startOp, startAddr, startData, rdAddr,
		input busy, rdData);
	modport core (input start, startOp, startAddr, startData, rdAddr,
		output busy, rdData);
endinterface

// ---- eac_nvm_core.sv ----
// Memory array with the self-timed erase and write engine
`timescale 1ns/1ps
module eac_nvm_core #(
	parameter int ATOMIC_CNT = eac_pkg::ATOMIC_CYCLES,
	parameter int SPLIT_CNT = eac_pkg::SPLIT_CYCLES
) (
	input wire logic clk, // Clock
	input wire logic srst, // Synchronous reset, high
	eac_core_if.core port // Start request and read port
);
	import eac_pkg::*;

	typedef struct packed {
		logic busy;
		eac_op_t op;
		logic [CNT_W-1:0] cnt;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} eac_core_state_t;

	eac_core_state_t st_ff;
	eac_core_state_t nxt_st;
	logic [7:0] mem [MEM_BYTES];
	logic done;

	////////////////////////////////////////////////////////////////////////
	// (RULE2) linear byte read
	assign port.rdData = mem[port.rdAddr];
	assign port.busy = st_ff.busy;
	assign done = st_ff.busy && (st_ff.cnt == CNT_W'(1));

	// Engine next state
	always_comb
	begin
		nxt_st = st_ff;
		if (st_ff.busy)
		begin
			// (RULE18) count clock ticks
			nxt_st.cnt = st_ff.cnt - CNT_W'(1);
			if (done)
				nxt_st.busy = 1'b0;
		end
		// (RULE20) reserved code never starts
		else if (port.start && port.startOp != OP_RESERVED)
		begin
			nxt_st.busy = 1'b1;
			nxt_st.op = port.startOp;
			nxt_st.addr = port.startAddr;
			nxt_st.data = port.startData;
			// (RULE5) duration per operation
			nxt_st.cnt = (port.startOp == OP_ATOMIC) ?
				CNT_W'(ATOMIC_CNT) : CNT_W'(SPLIT_CNT);
		end
		// (RULE17) reset spares a running operation; an unknown busy flag
		// at power-up takes the clearing branch, so one reset settles it
		if (srst)
		begin
			if (st_ff.busy)
				nxt_st.busy = !done;
			else
			begin
				nxt_st.busy = 1'b0;
				nxt_st.op = OP_ATOMIC;
				nxt_st.cnt = '0;
				nxt_st.addr = ADDR_RESET;
				nxt_st.data = DATA_RESET;
			end
		end
	end

	always_ff @(posedge clk)
		st_ff <= nxt_st;

	// Cell update at the end of the operation; write only clears bits
	always_ff @(posedge clk)
	begin
		if (done)
		begin
			unique case (st_ff.op)
				OP_ATOMIC: mem[st_ff.addr] <= st_ff.data;
				OP_ERASE: mem[st_ff.addr] <= ERASED_BYTE;
				OP_WRITE: mem[st_ff.addr] <= mem[st_ff.addr] & st_ff.data;
				default: mem[st_ff.addr] <= mem[st_ff.addr];
			endcase
		end
	end
endmodule

// ---- eac_nvm_ctrl.sv ----
// Register front end for the non-volatile data memory
`timescale 1ns/1ps
module eac_nvm_ctrl #(
	parameter int ATOMIC_CNT = eac_pkg::ATOMIC_CYCLES,
	parameter int SPLIT_CNT = eac_pkg::SPLIT_CYCLES
) (
	input wire logic clk, // Processor clock
	input wire logic srst, // Synchronous reset, high
	input wire logic [1:0] ioSel, // Register select
	input wire logic ioWe, // Write strobe
	input wire logic ioRe, // Read strobe
	input wire logic [7:0] ioWdata, // Write data
	output logic [7:0] ioRdata, // Read data, registered
	input wire logic globalIrqEnable, // Status register I bit
	output logic readyIrq, // Ready interrupt request, level
	output logic cpuStall // Halt the processor
);
	import eac_pkg::*;

	typedef struct packed {
		logic addrHigh;
		logic [7:0] addrLow;
		logic [7:0] data;
		eac_op_t opSel;
		logic readyIrqEnable;
		logic masterEnable;
		logic [2:0] masterCnt;
		logic [2:0] stallCnt;
		logic [7:0] rdata;
	} eac_ctrl_state_t;

	eac_ctrl_state_t st_ff;
	eac_ctrl_state_t nxt_st;
	logic busy;
	logic ctlWrite;
	logic readGo;
	logic trigGo;
	eac_op_t wrOp;

	eac_core_if link ();

	////////////////////////////////////////////////////////////////////////
	// Memory core
	eac_nvm_core #(
		.ATOMIC_CNT(ATOMIC_CNT),
		.SPLIT_CNT(SPLIT_CNT)
	) core (
		.clk(clk),
		.srst(srst),
		.port(link.core)
	);

	assign busy = link.busy;
	assign link.rdAddr = {st_ff.addrHigh, st_ff.addrLow};
	assign link.startAddr = {st_ff.addrHigh, st_ff.addrLow};
	assign link.startData = st_ff.data;
	assign link.startOp = wrOp;

	////////////////////////////////////////////////////////////////////////
	// Control write decode
	assign ctlWrite = ioWe && ioSel == REG_CONTROL;

	// (RULE6) op select frozen while busy
	assign wrOp = busy ? st_ff.opSel :
		eac_op_t'(ioWdata[CTL_OP_HI:CTL_OP_LO]);

	// (RULE14) reads refused while busy
	assign readGo = ctlWrite && ioWdata[CTL_READ_STROBE] && !busy;

	// (RULE10) trigger needs master enable already set
	assign trigGo = ctlWrite && ioWdata[CTL_PROGRAM_TRIGGER] &&
		st_ff.masterEnable && !busy && wrOp != OP_RESERVED;
	assign link.start = trigGo;

	////////////////////////////////////////////////////////////////////////
	// Register next state
	always_comb
	begin
		nxt_st = st_ff;

		// (RULE9) master enable window countdown
		if (st_ff.masterEnable)
		begin
			nxt_st.masterCnt = st_ff.masterCnt - 3'h1;
			if (st_ff.masterCnt == 3'h1)
				nxt_st.masterEnable = 1'b0;
		end

		// Stall counter drains one per cycle
		if (st_ff.stallCnt != 3'h0)
			nxt_st.stallCnt = st_ff.stallCnt - 3'h1;

		if (ioWe)
		begin
			unique case (ioSel)
				REG_ADDR_HIGH:
				begin
					// (RULE14) address frozen while busy
					if (!busy)
						nxt_st.addrHigh = ioWdata[0];
				end
				REG_ADDR_LOW:
				begin
					if (!busy)
						nxt_st.addrLow = ioWdata;
				end
				REG_DATA:
					nxt_st.data = ioWdata;
				REG_CONTROL:
				begin
					nxt_st.opSel = wrOp;
					nxt_st.readyIrqEnable = ioWdata[CTL_READY_IRQ_EN];
					// (RULE9) writing one opens a four cycle window
					if (ioWdata[CTL_MASTER_ENABLE])
					begin
						nxt_st.masterEnable = 1'b1;
						nxt_st.masterCnt = MASTER_WINDOW;
					end
					else
						nxt_st.masterEnable = 1'b0;
				end
			endcase
		end

		// (RULE13) immediate fetch with four cycle stall
		if (readGo)
		begin
			nxt_st.data = link.rdData;
			nxt_st.stallCnt = READ_STALL;
		end

		// (RULE12) accepted trigger stalls two cycles
		if (trigGo)
		begin
			nxt_st.stallCnt = PROGRAM_STALL;
			// A used window is spent so one arming gives one operation
			nxt_st.masterEnable = 1'b0;
		end

		// Read data is captured so the answer comes from a flip-flop
		if (ioRe)
		begin
			unique case (ioSel)
				// (RULE1) unused high bits read zero
				REG_ADDR_HIGH: nxt_st.rdata = {7'h00, st_ff.addrHigh};
				REG_ADDR_LOW: nxt_st.rdata = st_ff.addrLow;
				// (RULE3) data register returns fetched byte
				REG_DATA: nxt_st.rdata = st_ff.data;
				// (RULE4) reserved bits zero; (RULE11) trigger shows busy
				REG_CONTROL: nxt_st.rdata = {2'b00, st_ff.opSel,
					st_ff.readyIrqEnable, st_ff.masterEnable, busy, 1'b0};
			endcase
		end

		if (srst)
		begin
			nxt_st.data = DATA_RESET;
			nxt_st.readyIrqEnable = 1'b0;
			nxt_st.masterEnable = 1'b0;
			nxt_st.masterCnt = 3'h0;
			nxt_st.stallCnt = 3'h0;
			nxt_st.rdata = 8'h00;
			// (RULE7) op select and address kept while busy
			if (!busy)
			begin
				nxt_st.opSel = OP_ATOMIC;
				nxt_st.addrHigh = ADDR_RESET[8];
				nxt_st.addrLow = ADDR_RESET[7:0];
			end
		end
	end

	always_ff @(posedge clk)
		st_ff <= nxt_st;

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign ioRdata = st_ff.rdata;
	assign cpuStall = st_ff.stallCnt != 3'h0;

	// (RULE8) level request while ready and enabled
	assign readyIrq = st_ff.readyIrqEnable && globalIrqEnable && !busy;
endmodule

// ---- eac_props.sv ----
// Port checker for the data memory access block
`timescale 1ns/1ps
module eac_props
	import eac_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic srst, // Reset
	input wire logic [1:0] ioSel, // Select
	input wire logic ioWe, // Write
	input wire logic ioRe, // Read
	input wire logic [7:0] ioWdata, // Write data
	input wire logic [7:0] ioRdata, // Read data
	input wire logic globalIrqEnable, // Global enable
	input wire logic readyIrq, // Ready request
	input wire logic cpuStall // Stall
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic ctlWr;
	// Control writes are the cause of the irq disable and read stall checks
	assign ctlWr = ioWe && ioSel == REG_CONTROL;
	////////////////////////////////////////////////////////////////////
	reset_values_a: assert property (
		$fell(srst) |-> !cpuStall && !readyIrq && ioRdata == 8'h00)
		else $error("outputs not cleared by reset");
	irq_needs_gie_a: assert property (
		!globalIrqEnable |-> !readyIrq) else $error("request without gate");
	irq_disable_a: assert property (
		ctlWr && !ioWdata[CTL_READY_IRQ_EN] |=> !readyIrq)
		else $error("request kept after disable");
	// Ready high means idle, so the strobe must be taken
	read_stall_a: assert property (
		ctlWr && ioWdata[CTL_READ_STROBE] && readyIrq
		|=> cpuStall[*4] ##1 !cpuStall) else $error("read stall wrong");
	stall_length_a: assert property (
		$rose(cpuStall) |-> cpuStall[*2] ##1
		(!cpuStall or cpuStall[*2] ##1 !cpuStall))
		else $error("stall length wrong");
	busy_masks_irq_a: assert property (
		!cpuStall ##1 cpuStall[*2] ##1 !cpuStall |-> !readyIrq)
		else $error("ready request while programming");
	rdata_hold_a: assert property (
		!ioRe |=> $stable(ioRdata)) else $error("read data moved");
	ctl_reserved_a: assert property (
		ioRe && ioSel == REG_CONTROL |=> ioRdata[7:6] == 2'h0)
		else $error("reserved control bits set");
endmodule
bind eac_nvm_ctrl eac_props eac_props_inst (.clk, .srst, .ioSel, .ioWe,
	.ioRe, .ioWdata, .ioRdata, .globalIrqEnable, .readyIrq, .cpuStall);

// ---- eac_cpu_model.sv ----
// Processor-side model issuing I/O register cycles
`timescale 1ns/1ps
module eac_cpu_model
	import eac_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic cpuStall, // Halt from the block
	input wire logic [7:0] ioRdata, // Read data
	output logic [1:0] ioSel, // Select
	output logic ioWe, // Write strobe
	output logic ioRe, // Read strobe
	output logic [7:0] ioWdata // Write data
);
	// Idle bus at time zero
	initial
	begin
		ioSel = 2'h0;
		ioWe = 1'b0;
		ioRe = 1'b0;
		ioWdata = 8'h00;
	end
	// A halted core issues nothing; data is scrambled once released
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge clk);
		while (cpuStall)
			@(posedge clk);
		ioSel <= s;
		ioWdata <= d;
		ioWe <= 1'b1;
		@(posedge clk);
		ioWe <= 1'b0;
		ioWdata <= ~d;
	endtask
	// Data is taken just after the edge that accepts the strobe
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		@(posedge clk);
		while (cpuStall)
			@(posedge clk);
		ioSel <= s;
		ioRe <= 1'b1;
		@(posedge clk);
		ioRe <= 1'b0;
		#1 d = ioRdata;
	endtask
	task automatic ld_addr(input logic [8:0] a);
		wr(REG_ADDR_HIGH, {7'h0, a[8]});
		wr(REG_ADDR_LOW, a[7:0]);
	endtask
	task automatic wait_idle(output logic ok);
		logic [7:0] c;
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++)
		begin
			rd(REG_CONTROL, c);
			ok = c[CTL_PROGRAM_TRIGGER] === 1'b0;
		end
	endtask
endmodule

// ---- tb.sv ----
// Self-checking bench of the register front end
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("ERROR %s exp %h got %h", nm, e, g); \
		end \
	end
module tb;
	import eac_pkg::*;
	logic clk, srst, ioWe, ioRe, globalIrqEnable, readyIrq, cpuStall, ok;
	logic [1:0] ioSel;
	logic [7:0] ioWdata, ioRdata, d;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Select, write value, expected read back
	logic [17:0] rows [6] = '{{2'h0, 8'hff, 8'h01}, {2'h1, 8'h5a, 8'h5a},
		{2'h2, 8'hc3, 8'hc3}, {2'h3, 8'hf8, 8'h38}, {2'h3, 8'h20, 8'h20},
		{2'h3, 8'h10, 8'h10}};
	// Short program times keep the run brief
	eac_nvm_ctrl #(.ATOMIC_CNT(40), .SPLIT_CNT(20)) eac_nvm_ctrl_inst (
		.clk, .srst, .ioSel, .ioWe, .ioRe, .ioWdata, .ioRdata,
		.globalIrqEnable, .readyIrq, .cpuStall);
	eac_cpu_model cpu (.clk, .cpuStall, .ioRdata, .ioSel, .ioWe, .ioRe,
		.ioWdata);
	////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever
			#12.5 clk = ~clk;
	end
	// Hang guard well above the few hundred cycles needed
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Arm then trigger with ready interrupt enabled
	task automatic prog(input logic [1:0] op, input logic [8:0] a,
		input logic [7:0] v);
		cpu.ld_addr(a);
		cpu.wr(REG_DATA, v);
		cpu.wr(REG_CONTROL, {2'h0, op, 4'hc});
		cpu.wr(REG_CONTROL, {2'h0, op, 4'ha});
	endtask
	task automatic fetch(output logic [7:0] v);
		cpu.wr(REG_CONTROL, 8'h09);
		cpu.rd(REG_DATA, v);
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		srst = 1'b1;
		globalIrqEnable = 1'b0;
		repeat (4)
			@(posedge clk);
		srst <= 1'b0;
		cpu.rd(REG_CONTROL, d);
		`CHK("ctl reset", 8'h00, d)
		cpu.rd(REG_DATA, d);
		`CHK("data reset", DATA_RESET, d)
		foreach (rows[i])
		begin
			cpu.wr(rows[i][17:16], rows[i][15:8]);
			cpu.rd(rows[i][17:16], d);
			`CHK("readback", rows[i][7:0], d)
		end
		globalIrqEnable <= 1'b1;
		cpu.wr(REG_CONTROL, 8'h0a);
		cpu.rd(REG_CONTROL, d);
		`CHK("no master", 8'h08, d)
		`CHK("irq idle", 1'b1, readyIrq)
		cpu.wr(REG_CONTROL, 8'h0c);
		cpu.rd(REG_CONTROL, d);
		`CHK("master set", 8'h0c, d)
		repeat (4)
			@(posedge clk);
		cpu.wr(REG_CONTROL, 8'h0a);
		cpu.rd(REG_CONTROL, d);
		`CHK("master lapsed", 8'h08, d)
		prog(OP_ATOMIC, 9'h105, 8'h3c);
		// Trigger was taken at the last edge: exactly two stalled cycles
		#1 `CHK("trig stall", 1'b1, cpuStall)
		repeat (2)
			@(posedge clk);
		#1 `CHK("stall over", 1'b0, cpuStall)
		cpu.rd(REG_CONTROL, d);
		`CHK("busy", 8'h0a, d)
		`CHK("irq busy", 1'b0, readyIrq)
		// Address, op select and read strobe all refused while busy
		cpu.wr(REG_ADDR_LOW, 8'h00);
		cpu.wr(REG_CONTROL, 8'h18);
		cpu.wr(REG_CONTROL, 8'h09);
		cpu.rd(REG_DATA, d);
		`CHK("refused read", 8'h3c, d)
		cpu.rd(REG_CONTROL, d);
		`CHK("op kept", 8'h0a, d)
		cpu.wait_idle(ok);
		`CHK("idle", 1'b1, ok)
		cpu.rd(REG_ADDR_LOW, d);
		`CHK("addr kept", 8'h05, d)
		fetch(d);
		`CHK("atomic", 8'h3c, d)
		prog(OP_ERASE, 9'h104, 8'h00);
		cpu.wait_idle(ok);
		fetch(d);
		`CHK("erase", ERASED_BYTE, d)
		// write-only lands on an erased byte
		prog(OP_WRITE, 9'h104, 8'h5f);
		cpu.wait_idle(ok);
		fetch(d);
		`CHK("write", 8'h5f, d)
		prog(OP_RESERVED, 9'h104, 8'h00);
		cpu.rd(REG_CONTROL, d);
		`CHK("reserved idle", 1'b0, d[1])
		fetch(d);
		`CHK("reserved mem", 8'h5f, d)
		cpu.ld_addr(9'h105);
		fetch(d);
		`CHK("other byte", 8'h3c, d)
		// Reset in mid-programming must not stop the operation
		prog(OP_ATOMIC, 9'h105, 8'h77);
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		cpu.rd(REG_CONTROL, d);
		`CHK("busy past reset", 8'h02, d)
		cpu.wait_idle(ok);
		fetch(d);
		`CHK("survived", 8'h77, d)
		globalIrqEnable <= 1'b0;
		@(posedge clk);
		#1 `CHK("irq gated", 1'b0, readyIrq)
		end_sim();
	end
endmodule
